// [logic/biu_lane.sv]
`timescale 1ns/1ps
// maps one beat onto external lanes honouring width and port mode
module biu_lane
	import biu_pkg::*;
(
	// beat
	input  wire logic              narrow_i,
	input  wire logic              byte_pin_i,
	input  wire logic [1:0]        byte_en_i,
	input  wire logic              write_i,
	// lanes
	output logic                   upper_data_o,
	output logic                   port_two_pins_o,
	output logic                   low_byte_write_strobe_o,
	output logic                   high_byte_write_strobe_o
);

	assign port_two_pins_o = byte_pin_i;
	assign upper_data_o = !byte_pin_i && !narrow_i;
	assign low_byte_write_strobe_o  = write_i && byte_en_i[0];
	assign high_byte_write_strobe_o = write_i && byte_en_i[1] && upper_data_o;

endmodule : biu_lane

// [logic/biu_pkg.sv]
// Behaviour
// - the unit keeps a ten-byte instruction queue and a program address register naming the next byte to fetch.
// - while the bus is idle and the queue has room, the unit fetches more code on its own.
// - queued bytes go to the cpu only when the cpu asks for them.
// - a branch, call or interrupt empties the queue and restarts fetching at the target.
// - for a read the requester loads the data address, the unit reads into the data buffer and returns it.
// - for a write the requester gives the address, the unit stores the value in the data buffer and writes it out.
// - the data buffer is 32 bits and serves both the cpu and the dma controller.
// - internal cycles drive a 24-bit address bus, 32-bit code bus, 16-bit data bus and strobes.
// - external prefetch on a 16-bit bus depends on 4-byte or 8-byte alignment of the start address; the unit only uses even alignment, fetching one or two bytes.
// - external prefetch on an 8-bit bus depends on even, 4-byte or 8-byte alignment of the start address; the unit always fetches one byte.
// - external prefetch is shaped by branch origin, wait count and burst rom or dram space; the unit sets branch origin only at reset or a branch in ST_FETCH.
// - data cycles carry byte, word or double word, shaped by bus width, wait count and dram space.
// - with the width pin low the upper lanes carry data, with it high they are port pins.
// - an area set to 8-bit width leaves the upper lanes and the high-byte write strobe inactive.
// - recovery cycles can follow external accesses for prefetch and data alike.
// - internal memory sits on code and data bus, other peripherals on the data bus only.
package biu_pkg;

	localparam int unsigned QUEUE_DEPTH   = 10;
	localparam int unsigned ADDR_W        = 24;
	localparam int unsigned CODE_W        = 32;
	localparam int unsigned DATA_W        = 16;
	localparam int unsigned DBUF_W        = 32;
	localparam int unsigned WAIT_W        = 3;
	localparam int unsigned RECOV_W       = 2;
	localparam int unsigned QCNT_W        = 4;
	localparam logic [ADDR_W-1:0] RESET_PC = 24'h000000;

	typedef enum logic [1:0] {
		SIZE_BYTE,
		SIZE_WORD,
		SIZE_DWORD
	} xfer_size_t;

	// one data request from cpu or dma controller
	typedef struct packed {
		logic              write;
		xfer_size_t        size;
		logic [ADDR_W-1:0] addr;
		logic [DBUF_W-1:0] wdata;
	} data_req_t;

	// attributes of an address area, supplied by the area decoder
	typedef struct packed {
		logic               external;
		logic               narrow;
		logic               dram;
		logic               burst;
		logic [WAIT_W-1:0]  waits;
		logic [RECOV_W-1:0] recov;
	} area_attr_t;

	// internal bus command driven for one beat
	typedef struct packed {
		logic              valid;
		logic              code;
		logic              write;
		logic [ADDR_W-1:0] addr;
		logic [1:0]        byte_en;
		logic [DATA_W-1:0] wdata;
	} bus_cmd_t;

endpackage : biu_pkg

// [logic/biu_queue.sv]
`timescale 1ns/1ps
// byte queue of flip-flops; push up to four bytes, pop one
module biu_queue
	import biu_pkg::*;
(
	// clock and reset
	input  wire logic                clock_i,
	input  wire logic                rst_n_i,
	// control
	input  wire logic                flush_i,
	input  wire logic [2:0]          push_n_i,
	input  wire logic [CODE_W-1:0]   push_data_i,
	input  wire logic                pop_i,
	// state
	output logic      [7:0]          head_o,
	output logic      [QCNT_W-1:0]   count_o
);

	logic [7:0]        mem_q [QUEUE_DEPTH];
	logic [7:0]        mem_d [QUEUE_DEPTH];
	logic [QCNT_W-1:0] cnt_q;
	logic [QCNT_W-1:0] cnt_d;
	logic [QCNT_W-1:0] base;

	// shift out on pop, then append pushed bytes behind the survivors
	always_comb
	begin
		base  = cnt_q - QCNT_W'(pop_i);
		cnt_d = base + QCNT_W'(push_n_i);
		for (int i = 0; i < QUEUE_DEPTH; i++)
		begin
			mem_d[i] = (pop_i && i < QUEUE_DEPTH - 1) ? mem_q[i+1] : mem_q[i];
			for (int k = 0; k < 4; k++)
			begin
				if (k < push_n_i && i == base + k)
					mem_d[i] = push_data_i[k*8 +: 8];
			end
		end
		if (flush_i)
			cnt_d = '0;
	end

	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
			cnt_q <= '0;
		else
			cnt_q <= cnt_d;
		mem_q <= mem_d;
	end

	assign head_o  = mem_q[0];
	assign count_o = cnt_q;

endmodule : biu_queue

// [logic/bus_interface_unit.sv]
`timescale 1ns/1ps
// prefetch queue, data buffer and bus cycle sequencer
module bus_interface_unit
	import biu_pkg::*;
(
	// clock and reset
	input  wire logic                clock_i,
	input  wire logic                rst_n_i,
	// cpu instruction side
	input  wire logic                branch_i,
	input  wire logic [ADDR_W-1:0]   branch_addr_i,
	input  wire logic                code_req_i,
	output logic                     code_valid_o,
	output logic      [7:0]          code_byte_o,
	output logic      [QCNT_W-1:0]   queue_count_o,
	// cpu data side
	input  wire logic                cpu_req_i,
	input  wire data_req_t           cpu_cmd_i,
	output logic                     cpu_ready_o,
	output logic                     cpu_done_o,
	// dma controller data side
	input  wire logic                dma_controller_req_i,
	input  wire data_req_t           dma_controller_cmd_i,
	output logic                     dma_controller_ready_o,
	output logic                     dma_controller_done_o,
	// shared read result
	output logic      [DBUF_W-1:0]   rdata_o,
	// area attributes for current address
	output logic      [ADDR_W-1:0]   area_addr_o,
	input  wire area_attr_t          area_i,
	input  wire logic                byte_pin_i,
	// internal bus
	output bus_cmd_t                 bus_o,
	input  wire logic                bus_ack_i,
	input  wire logic [CODE_W-1:0]   code_bus_i,
	input  wire logic [DATA_W-1:0]   data_bus_i,
	// external lane control
	output logic                     upper_data_o,
	output logic                     port_two_pins_o,
	output logic                     low_byte_write_strobe_o,
	output logic                     high_byte_write_strobe_o,
	output logic                     recovery_o
);

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_FETCH,
		ST_DATA,
		ST_WAIT,
		ST_RECOV
	} state_t;

	state_t             st_q, st_d;
	logic [ADDR_W-1:0]  pc_q, pc_d;         // program address register
	logic [ADDR_W-1:0]  dadr_q, dadr_d;     // data address register
	logic [DBUF_W-1:0]  dbuf_q, dbuf_d;     // data buffer
	logic               dwr_q, dwr_d;
	logic               dma_q, dma_d;
	logic [2:0]         left_q, left_d;     // bytes still to move
	logic [1:0]         done_b_q, done_b_d; // bytes already moved
	logic [WAIT_W-1:0]  wcnt_q, wcnt_d;
	logic [RECOV_W-1:0] rcnt_q, rcnt_d;
	logic               brf_q, brf_d;       // set by reset or a fetch launch, cleared by its ack or a data launch
	logic               fetch_drop_q, fetch_drop_d;
	logic               cpu_done_q, cpu_done_d;
	logic               dma_done_q, dma_done_d;
	logic [2:0]         push_n;
	logic [CODE_W-1:0]  push_data;
	logic [QCNT_W-1:0]  qcnt;
	logic [7:0]         qhead;
	logic [2:0]         fetch_n;
	logic [1:0]         beat_n;
	logic               pop;
	logic               take_cpu, take_dma;

	assign code_valid_o  = (qcnt != '0) && !branch_i;
	assign pop           = code_req_i && code_valid_o;
	assign code_byte_o   = qhead;
	assign queue_count_o = qcnt;

	// data access granted before prefetch, dma before cpu
	assign take_dma = (st_q == ST_IDLE) && dma_controller_req_i && !branch_i;
	assign take_cpu = (st_q == ST_IDLE) && cpu_req_i && !dma_controller_req_i
		&& !branch_i;
	assign dma_controller_ready_o = take_dma;
	assign cpu_ready_o            = take_cpu;
	assign cpu_done_o             = cpu_done_q;
	assign dma_controller_done_o  = dma_done_q;
	assign rdata_o                = dbuf_q;
	assign recovery_o             = (st_q == ST_RECOV);

	// fetch width: one or two bytes up to the next even address on a wide bus
	// single bytes on a narrow bus, internal fetch uses code bus
	always_comb
	begin
		if (!area_i.external)
			fetch_n = 3'd4 - {1'b0, pc_q[1:0]};
		else if (area_i.narrow || byte_pin_i)
			fetch_n = 3'd1;
		else
			fetch_n = 3'd2 - {2'b0, pc_q[0]};
		// never overrun the queue
		if (QCNT_W'(fetch_n) > QCNT_W'(QUEUE_DEPTH) - qcnt)
			fetch_n = 3'(QCNT_W'(QUEUE_DEPTH) - qcnt);
		// data bus beat width
		if (area_i.external && (area_i.narrow || byte_pin_i))
			beat_n = 2'd1;
		else
			beat_n = 2'd2 - {1'b0, dadr_q[0]};
		if (beat_n > 2'(left_q) && left_q < 3'd2)
			beat_n = left_q[1:0];
	end

	// data beats decode the data address, everything else the program one
	assign area_addr_o = (st_q == ST_DATA || (st_q == ST_WAIT && !brf_q))
		? dadr_q : pc_q;

	// bus beat and sequencer
	always_comb
	begin
		st_d         = st_q;
		pc_d         = pc_q;
		dadr_d       = dadr_q;
		dbuf_d       = dbuf_q;
		dwr_d        = dwr_q;
		dma_d        = dma_q;
		left_d       = left_q;
		done_b_d     = done_b_q;
		wcnt_d       = wcnt_q;
		rcnt_d       = rcnt_q;
		brf_d        = brf_q;
		fetch_drop_d = fetch_drop_q && (st_q != ST_IDLE);
		cpu_done_d   = 1'b0;
		dma_done_d   = 1'b0;
		push_n       = '0;
		push_data    = code_bus_i >> {pc_q[1:0], 3'b000};
		bus_o        = '0;
		unique case (st_q)
			ST_IDLE:
			begin
				// address and write value latched into unit
				if (take_dma || take_cpu)
				begin
					dadr_d   = take_dma ? dma_controller_cmd_i.addr
						: cpu_cmd_i.addr;
					dbuf_d   = take_dma ? dma_controller_cmd_i.wdata
						: cpu_cmd_i.wdata;
					dwr_d    = take_dma ? dma_controller_cmd_i.write
						: cpu_cmd_i.write;
					dma_d    = take_dma;
					unique case (take_dma ? dma_controller_cmd_i.size
						: cpu_cmd_i.size)
						SIZE_BYTE:  left_d = 3'd1;
						SIZE_WORD:  left_d = 3'd2;
						default:    left_d = 3'd4;
					endcase
					done_b_d = '0;
					st_d     = ST_DATA;
				end
				// prefetch when idle and room remains
				else if (qcnt < QCNT_W'(QUEUE_DEPTH) && !branch_i)
					st_d = ST_FETCH;
			end
			ST_FETCH, ST_DATA:
			begin
				// drive address, code or data request
				bus_o.valid = 1'b1;
				bus_o.code  = (st_q == ST_FETCH) && !area_i.external;
				bus_o.write = (st_q == ST_DATA) && dwr_q;
				bus_o.addr  = (st_q == ST_FETCH) ? pc_q : dadr_q;
				bus_o.byte_en = (st_q == ST_FETCH) ? 2'b11
					: (beat_n == 2'd2 ? 2'b11 : (dadr_q[0] ? 2'b10 : 2'b01));
				bus_o.wdata = dbuf_q[{done_b_q, 3'b000} +: DATA_W];
				if (!dadr_q[0] && beat_n == 2'd1 && st_q == ST_DATA)
					bus_o.wdata = {8'h00, dbuf_q[{done_b_q, 3'b000} +: 8]};
				else if (dadr_q[0] && st_q == ST_DATA)
					bus_o.wdata = {dbuf_q[{done_b_q, 3'b000} +: 8], 8'h00};
				// programmed waits, extra one on dram or
				// a fetch outside burst rom that follows reset or a branch in ST_FETCH
				wcnt_d = area_i.waits;
				if (area_i.external && (area_i.dram
					|| (st_q == ST_FETCH && brf_q && !area_i.burst)))
					wcnt_d = area_i.waits + 1'b1;
				st_d = ST_WAIT;
				if (st_q == ST_FETCH)
					left_d = fetch_n;
				else
					left_d = left_q;
				brf_d = (st_q == ST_FETCH);
			end
			ST_WAIT:
			begin
				if (wcnt_q != '0)
					wcnt_d = wcnt_q - 1'b1;
				else if (bus_ack_i)
				begin
					if (brf_q)
					begin
						// bytes from a flushed fetch are dropped
						if (!fetch_drop_q)
						begin
							push_n = left_q;
							pc_d   = pc_q + ADDR_W'(left_q);
						end
						brf_d = 1'b0;
						left_d = '0;
					end
					else
					begin
						if (!dwr_q)
						begin
							if (beat_n == 2'd2)
								dbuf_d[{done_b_q, 3'b000} +: 16] = data_bus_i;
							else
								dbuf_d[{done_b_q, 3'b000} +: 8] = dadr_q[0]
									? data_bus_i[15:8] : data_bus_i[7:0];
						end
						dadr_d   = dadr_q + ADDR_W'(beat_n);
						done_b_d = done_b_q + beat_n;
						left_d   = left_q - 3'(beat_n);
					end
					rcnt_d = area_i.recov;
					if (area_i.external && area_i.recov != '0)
						st_d = ST_RECOV;
					else if (!brf_q && left_q != 3'(beat_n))
						st_d = ST_DATA;
					else
						st_d = ST_IDLE;
					if (!brf_q && left_q == 3'(beat_n))
					begin
						cpu_done_d = !dma_q;
						dma_done_d = dma_q;
					end
				end
			end
			ST_RECOV:
			begin
				rcnt_d = rcnt_q - 1'b1;
				if (rcnt_q == 2'd1)
					st_d = (left_q != '0) ? ST_DATA : ST_IDLE;
			end
			default: st_d = ST_IDLE;
		endcase
		// flush restarts fetching at the target
		if (branch_i)
		begin
			pc_d = branch_addr_i;
			fetch_drop_d = (st_q == ST_WAIT && brf_q) || st_q == ST_FETCH
				|| fetch_drop_d;
			if (st_q == ST_FETCH)
				st_d = ST_IDLE;
		end
	end

	// sequencer registers
	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			st_q         <= ST_IDLE;
			pc_q         <= RESET_PC;
			dadr_q       <= '0;
			dbuf_q       <= '0;
			dwr_q        <= 1'b0;
			dma_q        <= 1'b0;
			left_q       <= '0;
			done_b_q     <= '0;
			wcnt_q       <= '0;
			rcnt_q       <= '0;
			brf_q        <= 1'b1;
			fetch_drop_q <= 1'b0;
			cpu_done_q   <= 1'b0;
			dma_done_q   <= 1'b0;
		end
		else
		begin
			st_q         <= st_d;
			pc_q         <= pc_d;
			dadr_q       <= dadr_d;
			dbuf_q       <= dbuf_d;
			dwr_q        <= dwr_d;
			dma_q        <= dma_d;
			left_q       <= left_d;
			done_b_q     <= done_b_d;
			wcnt_q       <= wcnt_d;
			rcnt_q       <= rcnt_d;
			brf_q        <= brf_d;
			fetch_drop_q <= fetch_drop_d;
			cpu_done_q   <= cpu_done_d;
			dma_done_q   <= dma_done_d;
		end
	end

	biu_queue u_queue (
		.clock_i     (clock_i),
		.rst_n_i     (rst_n_i),
		.flush_i     (branch_i),
		.push_n_i    (push_n),
		.push_data_i (push_data),
		.pop_i       (pop),
		.head_o      (qhead),
		.count_o     (qcnt)
	);

	// lane control for the current beat
	biu_lane u_lane (
		.narrow_i                 (area_i.narrow),
		.byte_pin_i               (byte_pin_i),
		.byte_en_i                (bus_o.byte_en),
		.write_i                  (bus_o.write && area_i.external),
		.upper_data_o             (upper_data_o),
		.port_two_pins_o          (port_two_pins_o),
		.low_byte_write_strobe_o  (low_byte_write_strobe_o),
		.high_byte_write_strobe_o (high_byte_write_strobe_o)
	);

endmodule : bus_interface_unit

// [testbench/biu_assertions.sv]
`timescale 1ns/1ps
// port-level checks of the bus interface unit
module biu_assertions
	import biu_pkg::*;
(
	// clock and reset
	input wire logic              clock_i,
	input wire logic              rst_n_i,
	// cpu and dma side
	input wire logic              branch_i,
	input wire logic              code_req_i,
	input wire logic              code_valid_o,
	input wire logic [QCNT_W-1:0] queue_count_o,
	input wire logic              cpu_req_i,
	input wire data_req_t         cpu_cmd_i,
	input wire logic              cpu_ready_o,
	input wire logic              cpu_done_o,
	input wire logic              dma_controller_req_i,
	input wire logic              dma_controller_ready_o,
	// bus and lanes
	input wire area_attr_t        area_i,
	input wire logic              byte_pin_i,
	input wire bus_cmd_t          bus_o,
	input wire logic              bus_ack_i,
	input wire logic              upper_data_o,
	input wire logic              port_two_pins_o,
	input wire logic              high_byte_write_strobe_o
);
	default clocking dc @(posedge clock_i);
	endclocking
	default disable iff (!rst_n_i);

	// a taken cpu request and the data beat it launches
	sequence s_take;
		cpu_ready_o;
	endsequence
	sequence s_beat;
		bus_o.valid && !bus_o.code;
	endsequence

	AST_QMAX: assert property (queue_count_o <= 4'ha)
		else $error("queue above ten");
	AST_FETCH_IDLE: assert property (queue_count_o < 4'h7 && !cpu_req_i
		&& !dma_controller_req_i |-> ##[0:300] bus_o.valid && bus_o.code)
		else $error("no prefetch while idle");
	AST_VALID_HAS_BYTE: assert property (code_valid_o |-> queue_count_o != 4'h0)
		else $error("valid with empty queue");
	AST_POP_ONE: assert property (code_req_i && code_valid_o && !bus_ack_i
		|=> queue_count_o == $past(queue_count_o) - 4'h1)
		else $error("pop not by one");
	AST_NO_LOSS: assert property (!code_req_i && !branch_i
		|=> queue_count_o >= $past(queue_count_o))
		else $error("bytes lost without request");
	AST_FLUSH: assert property (branch_i |=> queue_count_o == 4'h0)
		else $error("queue kept after branch");
	AST_HIDE_IN_BRANCH: assert property (branch_i |-> !code_valid_o)
		else $error("code offered during branch");
	AST_REFUSE_IN_BRANCH: assert property (branch_i
		|-> !cpu_ready_o && !dma_controller_ready_o)
		else $error("request taken during branch");
	AST_BEAT_AFTER_TAKE: assert property (s_take |=> s_beat
		##0 bus_o.write == $past(cpu_cmd_i.write))
		else $error("no data beat after take");
	AST_DONE_BOUND: assert property (s_take |-> ##[2:120] cpu_done_o)
		else $error("transfer not done");
	AST_DMA_FIRST: assert property (dma_controller_req_i |-> !cpu_ready_o)
		else $error("cpu taken over dma");
	AST_PORT_MODE: assert property (byte_pin_i
		|-> port_two_pins_o && !upper_data_o)
		else $error("upper lanes not port pins");
	AST_NARROW: assert property (bus_o.valid && area_i.external
		&& area_i.narrow |-> !upper_data_o && !high_byte_write_strobe_o)
		else $error("upper lanes on narrow area");
endmodule : biu_assertions

// [testbench/biu_memory_model.sv]
`timescale 1ns/1ps
// memory and area map on the far side of the unit
module biu_memory_model
	import biu_pkg::*;
(
	// clock and reset
	input  wire logic              clock_i,
	input  wire logic              rst_n_i,
	// unit side
	input  wire logic              slow_i,
	input  wire bus_cmd_t          bus_i,
	input  wire logic [ADDR_W-1:0] area_addr_i,
	output area_attr_t             area_o,
	output logic                   ack_o,
	output logic      [CODE_W-1:0] code_bus_o,
	output logic      [DATA_W-1:0] data_bus_o
);
	logic [7:0]        mem [256];
	logic [ADDR_W-1:0] addr_q;
	logic              busy_q;
	int                wait_q;

	// bytes start equal to their low address bits
	initial
	begin
		for (int i = 0; i < 256; i++)
			mem[i] = i[7:0];
	end

	// area map: bit 23 external, 22 narrow, 21 dram, 20 recovery
	always_comb
	begin
		area_o = '0;
		area_o.external = area_addr_i[23];
		area_o.narrow = area_addr_i[23] & area_addr_i[22];
		area_o.dram = area_addr_i[23] & area_addr_i[21];
		area_o.waits = {2'h0, area_addr_i[23]};
		area_o.recov = {1'h0, area_addr_i[20]};
	end

	// both buses answer; lanes inverted when not acked
	always_comb
	begin
		code_bus_o = {mem[{addr_q[7:2], 2'h3}], mem[{addr_q[7:2], 2'h2}],
			mem[{addr_q[7:2], 2'h1}], mem[{addr_q[7:2], 2'h0}]};
		data_bus_o = {mem[{addr_q[7:1], 1'b1}], mem[{addr_q[7:1], 1'b0}]};
		if (addr_q[23] & addr_q[22])
			data_bus_o = {2{mem[addr_q[7:0]]}};
		if (!ack_o)
		begin
			code_bus_o = ~code_bus_o;
			data_bus_o = ~data_bus_o;
		end
	end

	// one answer per beat; slow mode adds cycles
	always @(posedge clock_i)
	begin
		ack_o <= 1'b0;
		if (!rst_n_i)
			busy_q <= 1'b0;
		else if (bus_i.valid)
		begin
			addr_q <= bus_i.addr;
			busy_q <= 1'b1;
			wait_q <= 1 + bus_i.addr[23] + bus_i.addr[21] + (slow_i ? 3 : 0);
			if (bus_i.write && bus_i.addr[23] && bus_i.addr[22])
				mem[bus_i.addr[7:0]] <= bus_i.byte_en[1] ?
					bus_i.wdata[15:8] : bus_i.wdata[7:0];
			else if (bus_i.write && bus_i.byte_en[0])
				mem[{bus_i.addr[7:1], 1'b0}] <= bus_i.wdata[7:0];
			if (bus_i.write && !(bus_i.addr[23] && bus_i.addr[22])
				&& bus_i.byte_en[1])
				mem[{bus_i.addr[7:1], 1'b1}] <= bus_i.wdata[15:8];
		end
		else if (busy_q && wait_q == 0)
		begin
			ack_o <= 1'b1;
			busy_q <= 1'b0;
		end
		else if (busy_q)
			wait_q <= wait_q - 1;
	end
endmodule : biu_memory_model

// [testbench/tb_bus_interface_unit.sv]
`timescale 1ns/1ps
// self-checking bench for the bus interface unit
module tb_bus_interface_unit;
	import biu_pkg::*;

	// design ports
	logic              clock_i;
	logic              rst_n_i;
	logic              branch_i;
	logic [ADDR_W-1:0] branch_addr_i;
	logic              code_req_i;
	logic              code_valid_o;
	logic [7:0]        code_byte_o;
	logic [QCNT_W-1:0] queue_count_o;
	logic              cpu_req_i;
	data_req_t         cpu_cmd_i;
	logic              cpu_ready_o;
	logic              cpu_done_o;
	logic              dma_controller_req_i;
	data_req_t         dma_controller_cmd_i;
	logic              dma_controller_ready_o;
	logic              dma_controller_done_o;
	logic [DBUF_W-1:0] rdata_o;
	logic [ADDR_W-1:0] area_addr_o;
	area_attr_t        area_i;
	logic              byte_pin_i;
	bus_cmd_t          bus_o;
	logic              bus_ack_i;
	logic [CODE_W-1:0] code_bus_i;
	logic [DATA_W-1:0] data_bus_i;
	logic              upper_data_o;
	logic              port_two_pins_o;
	logic              low_byte_write_strobe_o;
	logic              high_byte_write_strobe_o;
	logic              recovery_o;
	// bench state
	logic              slow;
	int                num_errors;
	int                tests_run;
	int                cycles;

	bus_interface_unit u_bus_interface_unit (.*);

	biu_memory_model u_biu_memory_model (
		.clock_i     (clock_i),
		.rst_n_i     (rst_n_i),
		.slow_i      (slow),
		.bus_i       (bus_o),
		.area_addr_i (area_addr_o),
		.area_o      (area_i),
		.ack_o       (bus_ack_i),
		.code_bus_o  (code_bus_i),
		.data_bus_o  (data_bus_i)
	);

	// free-running clock
	initial
	begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end

	task print_verdict;
		if (num_errors == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : print_verdict

	// cuts a hang short
	always @(posedge clock_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			num_errors++;
			print_verdict();
		end
	end

	task expect_eq(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			num_errors++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask : expect_eq

	// one data transfer; request held until the taking edge
	task xfer(input logic dma, input logic wr, input xfer_size_t sz,
		input logic [ADDR_W-1:0] a, input logic [DBUF_W-1:0] wd);
		int        n;
		data_req_t c;
		c = '{wr, sz, a, wd};
		n = 0;
		if (dma)
			dma_controller_cmd_i = c;
		else
			cpu_cmd_i = c;
		if (dma)
			dma_controller_req_i = 1'b1;
		else
			cpu_req_i = 1'b1;
		// ready is combinational: look mid-cycle, take on the next edge
		@(negedge clock_i);
		while ((dma ? dma_controller_ready_o : cpu_ready_o) !== 1'b1
			&& n < 99)
		begin
			@(negedge clock_i);
			n++;
		end
		@(posedge clock_i);
		#1;
		if (dma)
			dma_controller_req_i = 1'b0;
		else
			cpu_req_i = 1'b0;
		while ((dma ? dma_controller_done_o : cpu_done_o) !== 1'b1 && n < 300)
		begin
			@(posedge clock_i);
			#1;
			n++;
		end
		expect_eq(n < 300, 1'b1);
	endtask : xfer

	// takes bytes one at a time, each checked before it is popped
	task pop(input logic [7:0] first, input int cnt);
		int n;
		for (int i = 0; i < cnt; i++)
		begin
			n = 0;
			while (code_valid_o !== 1'b1 && n < 99)
			begin
				@(posedge clock_i);
				#1;
				n++;
			end
			expect_eq(code_byte_o, first + i[7:0]);
			code_req_i = 1'b1;
			@(posedge clock_i);
			#1;
			code_req_i = 1'b0;
			@(posedge clock_i);
			#1;
		end
	endtask : pop

	// queue fills after reset, holds, then drains across a refill
	task t_prefetch;
		int n;
		n = 0;
		while (queue_count_o !== 4'ha && n < 200)
		begin
			@(posedge clock_i);
			#1;
			n++;
		end
		expect_eq(queue_count_o, 4'ha);
		repeat (20) @(posedge clock_i);
		#1;
		expect_eq(queue_count_o, 4'ha);
		pop(8'h00, 12);
	endtask : t_prefetch

	// one-cycle branch pulse; the queue must read empty right after it
	task jump(input logic [ADDR_W-1:0] a);
		branch_addr_i = a;
		branch_i = 1'b1;
		@(posedge clock_i);
		#1;
		branch_i = 1'b0;
		expect_eq(queue_count_o, 4'h0);
	endtask : jump

	// odd internal target, then wide and narrow external code areas
	task t_branch;
		jump(24'h000123);
		pop(8'h23, 9);
		jump(24'h800041);
		pop(8'h41, 4);
		jump(24'hc00052);
		pop(8'h52, 3);
		jump(24'h000000);
	endtask : t_branch

	// internal, narrow, wide odd byte and slow dram areas
	task t_data;
		xfer(1'b0, 1'b0, SIZE_DWORD, 24'h000104, '0);
		expect_eq(rdata_o, 32'h07060504);
		expect_eq(recovery_o, 1'b0);
		xfer(1'b0, 1'b1, SIZE_DWORD, 24'hc00010, 32'hdeadbeef);
		xfer(1'b0, 1'b0, SIZE_DWORD, 24'hc00010, '0);
		expect_eq(rdata_o, 32'hdeadbeef);
		xfer(1'b0, 1'b1, SIZE_BYTE, 24'h800021, 32'h0000005a);
		xfer(1'b0, 1'b0, SIZE_WORD, 24'h800020, '0);
		expect_eq(rdata_o[15:0], 16'h5a20);
		slow = 1'b1;
		xfer(1'b0, 1'b1, SIZE_WORD, 24'hb00032, 32'h1234);
		expect_eq(recovery_o, 1'b1);
		xfer(1'b0, 1'b0, SIZE_WORD, 24'hb00032, '0);
		expect_eq(rdata_o[15:0], 16'h1234);
		slow = 1'b0;
		expect_eq(upper_data_o, 1'b1);
		expect_eq(port_two_pins_o, 1'b0);
		byte_pin_i = 1'b1;
		@(posedge clock_i);
		#1;
		expect_eq(port_two_pins_o, 1'b1);
		expect_eq(upper_data_o, 1'b0);
		byte_pin_i = 1'b0;
	endtask : t_data

	// cpu waits while the dma controller is served first
	task t_dma;
		cpu_cmd_i = '{1'b0, SIZE_DWORD, 24'h000104, 32'h0};
		cpu_req_i = 1'b1;
		xfer(1'b1, 1'b0, SIZE_WORD, 24'hc00010, '0);
		expect_eq(rdata_o[15:0], 16'hbeef);
		xfer(1'b0, 1'b0, SIZE_DWORD, 24'h000104, '0);
		expect_eq(rdata_o, 32'h07060504);
	endtask : t_dma

	// main sequence
	initial
	begin
		rst_n_i = 1'b0;
		branch_i = 1'b0;
		branch_addr_i = '0;
		code_req_i = 1'b0;
		cpu_req_i = 1'b0;
		cpu_cmd_i = '0;
		dma_controller_req_i = 1'b0;
		dma_controller_cmd_i = '0;
		byte_pin_i = 1'b0;
		slow = 1'b0;
		repeat (10) @(posedge clock_i);
		#1;
		rst_n_i = 1'b1;
		t_prefetch();
		t_branch();
		t_data();
		t_dma();
		print_verdict();
	end
endmodule : tb_bus_interface_unit

bind bus_interface_unit biu_assertions u_biu_assertions (.*);
